// >>> design/pfr_pkg.sv
package pfr_pkg;
   // Register indices; the byte address on the bus is four times the index.
   localparam logic [11:0] IDX_PIN_LEVEL_SAMPLE = 12'hF26;
   localparam logic [11:0] IDX_FAULT_RECOVERY_CONTROL = 12'hF28;
   localparam logic [11:0] IDX_FAULT_MASK = 12'hF30;
   localparam logic [11:0] IDX_FAULT_FLAGS = 12'hF31;
   localparam logic [11:0] IDX_IRQ_STATUS = 12'hF32;
   localparam logic [11:0] IDX_IRQ_MASK = 12'hF33;
   localparam int ADDR_W = 16;
   localparam int SRC_W = 4;
   localparam int IRQ_W = 3;
   // Fault source order inside the block.
   localparam int SRC_FIRST = 0;
   localparam int SRC_COMP = 1;
   localparam int SRC_SECOND = 2;
   localparam int SRC_DEBUG = 3;
   // Fault recovery control fields.
   localparam int FRC_FIRST_RESTART = 0;
   localparam int FRC_FIRST_IRQ = 1;
   localparam int FRC_COMP_RESTART = 2;
   localparam int FRC_COMP_IRQ = 3;
   localparam int FRC_SECOND_RESTART = 4;
   localparam int FRC_SECOND_IRQ = 5;
   localparam int FRC_DEBUG_RESTART = 6;
   localparam logic [7:0] FRC_WRITABLE = 8'h7F;
   // Flag and mask layout: debug in bit 5, second fault 2, comparator 1, first fault 0.
   localparam int FLG_DEBUG_BIT = 5;
   localparam int PIN_FAULT_BIT = 6;
   localparam logic [7:0] RESET_FRC = 8'h00;
   localparam logic [SRC_W-1:0] RESET_FAULT_MASK = 4'h0;
   localparam logic [IRQ_W-1:0] RESET_IRQ_MASK = 3'h0;
   localparam logic [7:0] RESET_PIN_SAMPLE = 8'h00;
   typedef enum logic [1:0] {
      PFR_RUN,
      PFR_FAULT,
      PFR_WAIT_PERIOD,
      PFR_WAIT_RELOAD
   } pfr_state_type;
endpackage

// >>> design/pfr_sticky.sv
`timescale 1ns/100ps
module pfr_sticky #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] clear,
   input wire logic [WIDTH-1:0] hold,
   output logic [WIDTH-1:0] flag
);

   // A set in the same cycle as a clear wins, so no event is lost.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         flag <= '0;
      end
      else
      begin
         flag <= set | (flag & ~(clear & ~hold));
      end
   end

endmodule // pfr_sticky

// >>> design/pfr_top.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////////////////////////
// Function
// RULE1: Software writes recovery control only with modulator disabled; enabled writes are ignored.
// RULE2: Debug automatic restart waits for all sources clear and a new period.
// RULE3: Other automatic restarts resume output control once all sources deassert.
// RULE4: Any restart bit set: wait sources clear, flags cleared, then a reload.
// RULE5: Second fault interrupt enable bit gates its interrupt on source assertion.
// RULE6: Comparator interrupt enable bit gates its interrupt on comparator assertion.
// RULE7: First fault interrupt enable bit gates its interrupt on pin assertion.
// RULE8: Software keeps the reserved top control bit at zero.
// RULE9: Pin sample bit 6 reads the first fault pin level.
// RULE10: Pin sample bits 5 to 0 read the six PWM pin levels.
// RULE11: Fault flags clear by writing one, not while active; masked sources never set.
// RULE12: While a fault is present all six outputs are forced off.
module pfr_top (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pfr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic modulator_enable,
   input wire logic debug_entry,
   input wire logic second_fault_input,
   input wire logic comparator_input,
   input wire logic first_fault_input,
   input wire logic pwm_reload,
   input wire logic period_start,
   input wire logic ch2_high_pin,
   input wire logic ch2_low_pin,
   input wire logic ch1_high_pin,
   input wire logic ch1_low_pin,
   input wire logic ch0_high_pin,
   input wire logic ch0_low_pin,
   output logic output_override,
   output logic irq
);

   //////////////////////////////////////////////////////////////////////////////////////////////
   logic [7:0] fault_recovery_control;
   logic [pfr_pkg::SRC_W-1:0] fault_mask;
   logic [pfr_pkg::IRQ_W-1:0] irq_mask;
   logic [7:0] pin_level_sample;
   logic [pfr_pkg::SRC_W-1:0] fault_flags;
   logic [pfr_pkg::IRQ_W-1:0] irq_status;
   logic [pfr_pkg::SRC_W-1:0] fault_cause;
   logic [pfr_pkg::SRC_W-1:0] src_prev;
   pfr_pkg::pfr_state_type state;
   pfr_pkg::pfr_state_type next_state;
   logic [pfr_pkg::SRC_W-1:0] src_raw;
   logic [pfr_pkg::SRC_W-1:0] src_active;
   logic [pfr_pkg::SRC_W-1:0] restart_sel;
   logic [pfr_pkg::SRC_W-1:0] flag_clear;
   logic [pfr_pkg::IRQ_W-1:0] irq_clear;
   logic [pfr_pkg::IRQ_W-1:0] irq_set;
   logic [pfr_pkg::IRQ_W-1:0] irq_en;
   logic [11:0] reg_index;
   logic addr_aligned;
   logic hit_pin;
   logic hit_frc;
   logic hit_fmask;
   logic hit_flags;
   logic hit_istat;
   logic hit_imask;
   logic hit_any;
   logic wr_commit;
   logic [31:0] next_prdata;

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Bus decode. The slave answers in the first access cycle, so pready is set in setup.
   assign reg_index = paddr[13:2];
   assign addr_aligned = (paddr[1:0] == 2'h0) && (paddr[pfr_pkg::ADDR_W-1:14] == 2'h0);
   assign hit_pin = addr_aligned && (reg_index == pfr_pkg::IDX_PIN_LEVEL_SAMPLE);
   assign hit_frc = addr_aligned && (reg_index == pfr_pkg::IDX_FAULT_RECOVERY_CONTROL);
   assign hit_fmask = addr_aligned && (reg_index == pfr_pkg::IDX_FAULT_MASK);
   assign hit_flags = addr_aligned && (reg_index == pfr_pkg::IDX_FAULT_FLAGS);
   assign hit_istat = addr_aligned && (reg_index == pfr_pkg::IDX_IRQ_STATUS);
   assign hit_imask = addr_aligned && (reg_index == pfr_pkg::IDX_IRQ_MASK);
   assign hit_any = hit_pin | hit_frc | hit_fmask | hit_flags | hit_istat | hit_imask;
   assign wr_commit = psel && penable && pready && pwrite && hit_any;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !hit_any;
      end
   end

   always_comb
   begin
      next_prdata = 32'h0000_0000;
      if (hit_pin)
      begin
         next_prdata[7:0] = pin_level_sample;
      end
      else if (hit_frc)
      begin
         next_prdata[7:0] = fault_recovery_control;
      end
      else if (hit_fmask)
      begin
         next_prdata[pfr_pkg::FLG_DEBUG_BIT] = fault_mask[pfr_pkg::SRC_DEBUG];
         next_prdata[2:0] = fault_mask[2:0];
      end
      else if (hit_flags)
      begin
         next_prdata[pfr_pkg::FLG_DEBUG_BIT] = fault_flags[pfr_pkg::SRC_DEBUG];
         next_prdata[2:0] = fault_flags[2:0];
      end
      else if (hit_istat)
      begin
         next_prdata[pfr_pkg::IRQ_W-1:0] = irq_status;
      end
      else if (hit_imask)
      begin
         next_prdata[pfr_pkg::IRQ_W-1:0] = irq_mask;
      end
   end

   // Read data is captured in the setup cycle and held through the access cycle.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (psel && !penable && !pwrite)
      begin
         prdata <= next_prdata;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Writable configuration.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fault_recovery_control <= pfr_pkg::RESET_FRC;
      end
      else if (wr_commit && hit_frc && !modulator_enable) // RULE1
      begin
         // The reserved top bit is kept at zero whatever software writes.
         fault_recovery_control <= pwdata[7:0] & pfr_pkg::FRC_WRITABLE; // RULE8
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fault_mask <= pfr_pkg::RESET_FAULT_MASK;
      end
      else if (wr_commit && hit_fmask && !modulator_enable)
      begin
         fault_mask <= {pwdata[pfr_pkg::FLG_DEBUG_BIT], pwdata[2:0]};
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq_mask <= pfr_pkg::RESET_IRQ_MASK;
      end
      else if (wr_commit && hit_imask)
      begin
         irq_mask <= pwdata[pfr_pkg::IRQ_W-1:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Pin sampling. Writes to this register have no effect; it always shows the pins.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_level_sample <= pfr_pkg::RESET_PIN_SAMPLE;
      end
      else
      begin
         pin_level_sample <= {1'b0, first_fault_input, // RULE9
                              ch2_high_pin, ch2_low_pin, ch1_high_pin, // RULE10
                              ch1_low_pin, ch0_high_pin, ch0_low_pin}; // RULE10
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Fault sources and flags.
   assign src_raw = {debug_entry, second_fault_input, comparator_input, first_fault_input};
   assign src_active = src_raw & ~fault_mask; // RULE11
   assign flag_clear = wr_commit && hit_flags ?
                       {pwdata[pfr_pkg::FLG_DEBUG_BIT], pwdata[2:0]} : 4'h0;

   // A flag cannot be cleared while its source still asserts.
   pfr_sticky #(
      .WIDTH(pfr_pkg::SRC_W)
   ) u_fault_flags (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .set(src_active), // RULE11
      .clear(flag_clear), // RULE11
      .hold(src_active), // RULE11
      .flag(fault_flags)
   );

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Interrupts on assertion of each enabled external fault source.
   assign irq_en = {fault_recovery_control[pfr_pkg::FRC_SECOND_IRQ],
                    fault_recovery_control[pfr_pkg::FRC_COMP_IRQ],
                    fault_recovery_control[pfr_pkg::FRC_FIRST_IRQ]};
   assign irq_set[2] = src_active[pfr_pkg::SRC_SECOND] && !src_prev[pfr_pkg::SRC_SECOND]
                       && irq_en[2]; // RULE5
   assign irq_set[1] = src_active[pfr_pkg::SRC_COMP] && !src_prev[pfr_pkg::SRC_COMP]
                       && irq_en[1]; // RULE6
   assign irq_set[0] = src_active[pfr_pkg::SRC_FIRST] && !src_prev[pfr_pkg::SRC_FIRST]
                       && irq_en[0]; // RULE7
   assign irq_clear = wr_commit && hit_istat ? pwdata[pfr_pkg::IRQ_W-1:0] : 3'h0;

   pfr_sticky #(
      .WIDTH(pfr_pkg::IRQ_W)
   ) u_irq_status (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .set(irq_set),
      .clear(irq_clear),
      .hold(3'h0),
      .flag(irq_status)
   );

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         src_prev <= 4'h0;
         irq <= 1'b0;
      end
      else
      begin
         src_prev <= src_active;
         // Clearing an enable bit drops a pending interrupt one cycle later, as irq is registered.
         irq <= |(irq_status & irq_mask & irq_en); // RULE5 RULE6 RULE7
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Recovery sequencing.
   assign restart_sel = {fault_recovery_control[pfr_pkg::FRC_DEBUG_RESTART],
                         fault_recovery_control[pfr_pkg::FRC_SECOND_RESTART],
                         fault_recovery_control[pfr_pkg::FRC_COMP_RESTART],
                         fault_recovery_control[pfr_pkg::FRC_FIRST_RESTART]};

   always_comb
   begin
      next_state = state;
      case (state)
         pfr_pkg::PFR_RUN:
         begin
            if (|src_active)
            begin
               next_state = pfr_pkg::PFR_FAULT;
            end
         end
         pfr_pkg::PFR_FAULT:
         begin
            if (|src_active)
            begin
               next_state = pfr_pkg::PFR_FAULT;
            end
            else if (|restart_sel)
            begin
               next_state = pfr_pkg::PFR_WAIT_RELOAD; // RULE4
            end
            else if (fault_cause[pfr_pkg::SRC_DEBUG])
            begin
               next_state = pfr_pkg::PFR_WAIT_PERIOD; // RULE2
            end
            else
            begin
               next_state = pfr_pkg::PFR_RUN; // RULE3
            end
         end
         pfr_pkg::PFR_WAIT_PERIOD:
         begin
            if (|src_active)
            begin
               next_state = pfr_pkg::PFR_FAULT;
            end
            else if (period_start)
            begin
               next_state = pfr_pkg::PFR_RUN; // RULE2
            end
         end
         pfr_pkg::PFR_WAIT_RELOAD:
         begin
            // A reload only counts once every flag has already been cleared.
            if (|src_active)
            begin
               next_state = pfr_pkg::PFR_FAULT;
            end
            else if (fault_flags == 4'h0 && pwm_reload)
            begin
               next_state = pfr_pkg::PFR_RUN; // RULE4
            end
         end
         default:
         begin
            next_state = pfr_pkg::PFR_FAULT;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= pfr_pkg::PFR_RUN;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Causes gathered over one fault episode choose the restart path.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fault_cause <= 4'h0;
      end
      else if (state == pfr_pkg::PFR_RUN)
      begin
         fault_cause <= src_active;
      end
      else
      begin
         fault_cause <= fault_cause | src_active;
      end
   end

   // Override is registered; it follows a new fault one cycle later.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         output_override <= 1'b0;
      end
      else
      begin
         output_override <= (next_state != pfr_pkg::PFR_RUN); // RULE12
      end
   end

endmodule // pfr_top

// >>> dv/pfr_top_properties.sv
`timescale 1ns/100ps
module pfr_top_properties (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pfr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic modulator_enable,
   input wire logic debug_entry,
   input wire logic second_fault_input,
   input wire logic comparator_input,
   input wire logic first_fault_input,
   input wire logic pwm_reload,
   input wire logic period_start,
   input wire logic output_override,
   input wire logic irq
);
   logic [7:0] frc_sh;
   logic [7:0] msk_sh;
   logic [2:0] imk_sh;
   logic dbg_c;
   logic [3:0] act;
   logic wr_ok;
   logic rd_su;
   logic [7:0] rst_sel;
   assign act = {debug_entry & ~msk_sh[5], second_fault_input & ~msk_sh[2],
      comparator_input & ~msk_sh[1], first_fault_input & ~msk_sh[0]};
   assign wr_ok = psel & penable & pready & pwrite;
   assign rd_su = psel & ~penable & ~pwrite;
   assign rst_sel = frc_sh & 8'h55;
   //////////////////////////////////////////////////////////////////////////////
   // Shadows of the mode registers, so the mode is known from the bus and modulator_enable.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         frc_sh <= 8'h00;
         msk_sh <= 8'h00;
         imk_sh <= 3'h0;
      end
      else if (wr_ok)
      begin
         if (!modulator_enable && paddr == 16'h3CA0)
            frc_sh <= pwdata[7:0] & 8'h7F;
         if (!modulator_enable && paddr == 16'h3CC0)
            msk_sh <= pwdata[7:0] & 8'h27;
         if (paddr == 16'h3CCC)
            imk_sh <= pwdata[2:0];
      end
   end
   // A debug fault stays the cause until the outputs are handed back.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         dbg_c <= 1'b0;
      else if (act[3])
         dbg_c <= 1'b1;
      else if (!output_override && act == 4'h0)
         dbg_c <= 1'b0;
   end
   //////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   AST_APB_ANSWER: assert property (psel && !penable |=> pready)
      else $error("no answer in the access cycle");
   AST_FAULT_FORCE: assert property (|act |=> output_override)
      else $error("outputs not forced off during a fault");
   AST_AUTO_RELEASE: assert property
      ((rst_sel == 8'h00 && !dbg_c && act == 4'h0) [*3] |-> !output_override)
      else $error("automatic release missing");
   AST_DEBUG_HOLD: assert property
      ((dbg_c && rst_sel == 8'h00 && output_override && !period_start) [*3] |=> output_override)
      else $error("debug fault released without a new period");
   AST_SW_HOLD: assert property
      ((rst_sel != 8'h00 && output_override && !pwm_reload) [*3] |=> output_override)
      else $error("software recovery released without a reload");
   AST_IRQ_SECOND: assert property
      ($rose(second_fault_input) && !msk_sh[2] && frc_sh[5] && imk_sh[2] |-> ##[1:3] irq)
      else $error("second fault interrupt missing");
   AST_IRQ_COMP: assert property
      ($rose(comparator_input) && !msk_sh[1] && frc_sh[3] && imk_sh[1] |-> ##[1:3] irq)
      else $error("comparator interrupt missing");
   AST_IRQ_FIRST: assert property
      ($rose(first_fault_input) && !msk_sh[0] && frc_sh[1] && imk_sh[0] |-> ##[1:3] irq)
      else $error("first fault interrupt missing");
   AST_FLAG_HELD: assert property
      (rd_su && paddr == 16'h3CC4 && act[0] && $past(act[0]) |=> prdata[0])
      else $error("fault flag not set while its source is active");
   AST_PIN_FAULT: assert property
      (rd_su && paddr == 16'h3C98 && $stable(first_fault_input)
      && first_fault_input == $past(first_fault_input, 2)
      |=> prdata[7:6] == {1'b0, $past(first_fault_input)})
      else $error("pin sample shows wrong fault pin level");
   COV_RELEASE: cover property (output_override ##1 !output_override);
   COV_IRQ: cover property (irq);
   COV_BLOCKED: cover property (wr_ok && modulator_enable && paddr == 16'h3CA0);
endmodule // pfr_top_properties
bind pfr_top pfr_top_properties u_props (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .modulator_enable(modulator_enable), .debug_entry(debug_entry),
   .second_fault_input(second_fault_input), .comparator_input(comparator_input),
   .first_fault_input(first_fault_input), .pwm_reload(pwm_reload),
   .period_start(period_start), .output_override(output_override), .irq(irq));

// >>> dv/pwm_fault_recovery_and_pin_sample_tb.sv
`timescale 1ns/100ps
module pwm_fault_recovery_and_pin_sample_tb;
   localparam logic [15:0] A_PIN = 16'h3C98;
   localparam logic [15:0] A_FRC = 16'h3CA0;
   localparam logic [15:0] A_MSK = 16'h3CC0;
   localparam logic [15:0] A_FLG = 16'h3CC4;
   localparam logic [15:0] A_IST = 16'h3CC8;
   localparam logic [15:0] A_IMK = 16'h3CCC;
   logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, rerr;
   logic modulator_enable, pwm_reload, period_start, output_override, irq;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [3:0] srcs;
   logic [5:0] pins;
   int n_errors = 0;
   int samples_checked = 0;
   pfr_top DUT (
      .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .modulator_enable(modulator_enable), .debug_entry(srcs[3]),
      .second_fault_input(srcs[2]), .comparator_input(srcs[1]), .first_fault_input(srcs[0]),
      .pwm_reload(pwm_reload), .period_start(period_start), .ch2_high_pin(pins[5]),
      .ch2_low_pin(pins[4]), .ch1_high_pin(pins[3]), .ch1_low_pin(pins[2]),
      .ch0_high_pin(pins[1]), .ch0_low_pin(pins[0]), .output_override(output_override),
      .irq(irq));
   //////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Request and qualifiers stay put until pready is seen high at an edge.
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16)
      begin
         n_errors++;
         end_of_test();
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, {24'h0, exp}, rdata);
   endtask
   task automatic flt(input logic [3:0] v, input int len);
      @(posedge clk_sys);
      srcs <= v;
      repeat (len) @(posedge clk_sys);
      srcs <= 4'h0;
   endtask
   task automatic pulse_ev(input logic reload);
      @(posedge clk_sys);
      if (reload)
         pwm_reload <= 1'b1;
      else
         period_start <= 1'b1;
      @(posedge clk_sys);
      pwm_reload <= 1'b0;
      period_start <= 1'b0;
   endtask
   task automatic hold_chk(input logic exp);
      repeat (4) @(posedge clk_sys);
      check("override", {31'h0, exp}, {31'h0, output_override});
   endtask
   task automatic wait_out(input string what, input logic exp);
      int n;
      logic v;
      n = 0;
      v = ~exp;
      while (v !== exp && n < 12)
      begin
         @(posedge clk_sys);
         v = (what == "irq") ? irq : output_override;
         n++;
      end
      check(what, {31'h0, exp}, {31'h0, v});
      if (v !== exp)
         end_of_test();
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial
   begin
      {arst_n, psel, penable, pwrite, modulator_enable, pwm_reload, period_start} = 7'h00;
      paddr = 16'h0000;
      pwdata = 32'h0;
      srcs = 4'h0;
      pins = 6'h00;
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      rd_chk("control reset", A_FRC, 8'h00);
      rd_chk("pin reset", A_PIN, 8'h00);
      apb(1'b0, 16'h3CA2, 32'h0);
      check("unmapped error", 32'h1, {31'h0, rerr});
      wr(A_FRC, 8'hFF);
      rd_chk("control", A_FRC, 8'h7F);
      modulator_enable <= 1'b1;
      wr(A_FRC, 8'h00);
      rd_chk("control locked", A_FRC, 8'h7F);
      modulator_enable <= 1'b0;
      wr(A_FRC, 8'h00);
      rd_chk("control", A_FRC, 8'h00);
      $display("test register access done");
      // Sources masked so the walking pin pattern cannot start a fault.
      wr(A_MSK, 8'h27);
      for (int i = 0; i < 7; i++)
      begin
         {srcs[0], pins} <= 7'h01 << i;
         repeat (3) @(posedge clk_sys);
         rd_chk("pin sample", A_PIN, 8'h01 << i);
      end
      {srcs[0], pins} <= 7'h00;
      wr(A_PIN, 8'hFF);
      rd_chk("pin sample", A_PIN, 8'h00);
      wr(A_MSK, 8'h00);
      $display("test pin sample done");
      @(posedge clk_sys);
      srcs <= 4'h1;
      hold_chk(1'b1);
      rd_chk("flags", A_FLG, 8'h01);
      wr(A_FLG, 8'h01);
      rd_chk("flags held", A_FLG, 8'h01);
      srcs <= 4'h0;
      wait_out("override", 1'b0);
      wr(A_FLG, 8'h01);
      rd_chk("flags", A_FLG, 8'h00);
      wr(A_MSK, 8'h01);
      flt(4'h1, 4);
      hold_chk(1'b0);
      rd_chk("masked flags", A_FLG, 8'h00);
      wr(A_MSK, 8'h00);
      flt(4'h8, 3);
      hold_chk(1'b1);
      pulse_ev(1'b0);
      wait_out("override", 1'b0);
      wr(A_FLG, 8'h20);
      $display("test automatic recovery done");
      for (int k = 0; k < 4; k++)
      begin
         wr(A_FRC, 8'h01 << (2 * k));
         flt(4'h2, 3);
         hold_chk(1'b1);
         pulse_ev(1'b1);
         hold_chk(1'b1);
         wr(A_FLG, 8'h27);
         hold_chk(1'b1);
         pulse_ev(1'b1);
         wait_out("override", 1'b0);
      end
      $display("test software recovery done");
      wr(A_FRC, 8'h2A);
      wr(A_IMK, 8'h07);
      for (int i = 0; i < 3; i++)
      begin
         flt(4'h1 << i, 2);
         wait_out("irq", 1'b1);
         rd_chk("irq status", A_IST, 8'h01 << i);
         wr(A_IST, 8'h01 << i);
         wait_out("irq", 1'b0);
      end
      wr(A_IMK, 8'h00);
      flt(4'h2, 2);
      wait_out("irq", 1'b0);
      rd_chk("irq status", A_IST, 8'h02);
      wr(A_IST, 8'h02);
      wr(A_FRC, 8'h00);
      wr(A_IMK, 8'h07);
      flt(4'h1, 2);
      // Automatic recovery has already handed the outputs back by the time of this look.
      hold_chk(1'b0);
      rd_chk("irq status", A_IST, 8'h00);
      $display("test interrupts done");
      end_of_test();
   end
endmodule // pwm_fault_recovery_and_pin_sample_tb
